// ===== verilog/nrw_pkg.sv
// Constants, types and register map of the NFC reception window timers.
package nrw_pkg;

  // ------------------------------------------------------------------
  // Register byte addresses
  // ------------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_MRT  = 8'h04;
  localparam logic [7:0] ADDR_NRT  = 8'h08;
  localparam logic [7:0] ADDR_CMD  = 8'h0C;
  localparam logic [7:0] ADDR_STAT = 8'h10;
  localparam logic [7:0] ADDR_FLAG = 8'h14;

  // ------------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------------
  localparam int CTRL_MRT_STEP = 0;
  localparam int CTRL_NRT_STEP = 1;
  localparam int CTRL_NRT_EMV  = 2;
  localparam int CTRL_NRT_NFC  = 3;
  localparam int CTRL_SQ_AUTO  = 4;
  localparam int CTRL_SQ_CMD   = 5;
  localparam int CTRL_MODE_LSB = 8;
  localparam int CMD_START_MRT = 0;
  localparam int CMD_START_NRT = 1;
  localparam int CMD_STOP_NRT  = 2;
  localparam int CMD_STOP_ALL  = 3;
  localparam int FLAG_NRE      = 0;

  // ------------------------------------------------------------------
  // Reset values and coarse step lengths (in carrier cycles fc; one base tick is 64 fc)
  // ------------------------------------------------------------------
  localparam logic [15:0] CTRL_RST = 16'h0000;
  localparam logic [7:0]  MRT_RST  = 8'h00;
  localparam logic [15:0] NRT_RST  = 16'h0000;
  localparam int          FC_PER_BASE   = 64;
  localparam int          MRT_COARSE_FC = 512;
  localparam int          NRT_COARSE_FC = 4096;
  localparam logic [2:0]  MRT_PRE_LAST  = 3'(MRT_COARSE_FC / FC_PER_BASE - 1);
  localparam logic [5:0]  NRT_PRE_LAST  = 6'(NRT_COARSE_FC / FC_PER_BASE - 1);

  // ------------------------------------------------------------------
  // Types
  // ------------------------------------------------------------------
  typedef enum logic [2:0] {
    MODE_READER = 3'h0, MODE_ACT_INIT = 3'h1, MODE_ACT_TGT = 3'h2,
    MODE_PAS_TGT = 3'h3, MODE_BITRATE = 3'h4, MODE_LP_TGT = 3'h5
  } nrw_mode_t;

  typedef enum logic {TMR_IDLE = 1'b0, TMR_RUN = 1'b1} nrw_tmr_st_t;

  typedef struct packed {
    logic tx_eof;      // Transmit end-of-frame completed.
    logic tx_off_gpt;  // Own field off, timed by the general timer.
    logic peer_on;     // External field detector saw peer field on.
    logic reply_start; // Start of a reply detected.
    logic reply_busy;  // A reply is being received.
    logic osc_ok;      // Crystal oscillator stable.
  } nrw_evt_t;

  typedef struct packed {
    logic rx_on;
    logic squelch_on;
    logic watch_rx;
    logic nre_irq;
  } nrw_out_t;

endpackage : nrw_pkg

// ===== verilog/nrw_timers.sv
// Receive-mask and no-response timers with their APB register slave.
//
// Design decisions made here: register access over APB and the address map.
`timescale 1ns/100ps
module nrw_timers (
  input  wire logic            pclk,
  input  wire logic            presetn,
  input  wire logic            psel,
  input  wire logic            penable,
  input  wire logic            pwrite,
  input  wire logic [7:0]      paddr,
  input  wire logic [31:0]     pwdata,
  output logic      [31:0]     prdata,
  output logic                 pready,
  output logic                 pslverr,
  input  wire logic            fc64_tick,
  input  wire logic            rc_osc_pin,
  input  wire nrw_pkg::nrw_evt_t evt,
  output nrw_pkg::nrw_out_t    out
);
  import nrw_pkg::*;

  // ------------------------------------------------------------------
  // Behaviour overview
  // ------------------------------------------------------------------
  // The mask timer keeps the receiver closed after a transmission or after
  // the peer turns its field on in an active, passive target or low-power target mode; it never raises an interrupt.
  // The response timer waits for the start of a reply and pulses nre_irq
  // when the wait runs out; a sticky flag keeps the event for software.
  // Both timers count the carrier tick, and a prescaler per timer
  // stretches it to the coarse step. A value of 0 behaves as 1, so every
  // run lasts at least one step.
  // Settings are read live: software must leave them alone while a timer
  // runs, since a change mid-run bends the count already under way.
  // The bus answers every access after one wait state. That costs a cycle
  // per access but lets prdata, pready and pslverr come straight from flops.
  // In low-power target mode the mask timer steps on RC edges until the
  // crystal is stable, so its first steps are only approximate.

  // ------------------------------------------------------------------
  // State
  // ------------------------------------------------------------------
  // All state lives in one packed struct; the comb block fills next_s.
  typedef struct packed {
    logic [15:0]  ctrl;
    logic [7:0]   mrt_val;
    logic [15:0]  nrt_val;
    nrw_tmr_st_t  mrt_st;
    logic [7:0]   mrt_cnt;
    logic [2:0]   mrt_pre;
    logic         mrt_sq;
    nrw_tmr_st_t  nrt_st;
    logic [15:0]  nrt_cnt;
    logic [5:0]   nrt_pre;
    logic         nre_flag;
    nrw_out_t     out;
    logic         pready;
    logic         pslverr;
    logic [31:0]  prdata;
    logic [1:0]   rc_sync;
    logic         rc_prev;
  } nrw_state_t;

  nrw_state_t s;
  nrw_state_t next_s;

  // Decoded strobes of this cycle, recomputed on every clock.
  nrw_mode_t  mode;
  logic       wr_done;
  logic [3:0] cmd;
  logic       rc_edge;
  logic       mrt_tick;
  logic       mrt_start;
  logic       nrt_tick;
  logic       nrt_auto;
  logic       nrt_start;
  logic       nrt_stop;
  logic       nre_ev;
  logic       act_mode;

  // Outputs come straight from the state flops.
  assign prdata  = s.prdata;
  assign pready  = s.pready;
  assign pslverr = s.pslverr;
  assign out     = s.out;

  // ------------------------------------------------------------------
  // Next-state logic
  // ------------------------------------------------------------------
  // One combinational pass: bus access, event decode, then both timers.
  always_comb begin
    next_s   = s;
    mode     = nrw_mode_t'(s.ctrl[CTRL_MODE_LSB +: 3]);
    act_mode = (mode == MODE_ACT_INIT) || (mode == MODE_ACT_TGT);
    nre_ev   = 1'b0;

    // The RC clock is foreign; only the second stage feeds the edge finder.
    next_s.rc_sync = {s.rc_sync[0], rc_osc_pin};
    next_s.rc_prev = s.rc_sync[1];
    rc_edge        = s.rc_sync[1] & ~s.rc_prev;

    // APB: one wait state, so every answer is registered.
    next_s.pready  = psel & penable & ~s.pready;
    next_s.pslverr = 1'b0;
    wr_done        = psel & penable & s.pready & pwrite;
    // Read data is latched at the first access edge and held until the next.
    if (psel && penable && !s.pready) begin
      next_s.prdata = 32'h0000_0000;
      unique case (paddr)
        ADDR_CTRL: next_s.prdata[15:0] = s.ctrl;
        ADDR_MRT:  next_s.prdata[7:0]  = s.mrt_val;
        ADDR_NRT:  next_s.prdata[15:0] = s.nrt_val;
        ADDR_CMD:  next_s.prdata       = 32'h0000_0000;
        ADDR_STAT: next_s.prdata = {s.nrt_cnt, s.mrt_cnt, 2'h0, evt.osc_ok,
                                    s.out.watch_rx, s.out.squelch_on,
                                    s.out.rx_on, s.nrt_st, s.mrt_st};
        ADDR_FLAG: next_s.prdata[FLAG_NRE] = s.nre_flag;
        default:   next_s.pslverr = 1'b1;
      endcase
    end
    // Commands are strobes: they act only at the edge that ends the write.
    cmd = (wr_done && paddr == ADDR_CMD) ? pwdata[3:0] : 4'h0;
    if (wr_done) begin
      if (paddr == ADDR_CTRL) next_s.ctrl    = pwdata[15:0];
      if (paddr == ADDR_MRT)  next_s.mrt_val = pwdata[7:0];
      if (paddr == ADDR_NRT)  next_s.nrt_val = pwdata[15:0];
    end

    // Mask timer tick: RC edges stand in until the crystal settles.
    // The RC path has no prescaler: one RC edge is one coarse step.
    if (mode == MODE_LP_TGT && !evt.osc_ok) begin
      mrt_tick = rc_edge;
    end else if (s.ctrl[CTRL_MRT_STEP]) begin
      mrt_tick = fc64_tick && (s.mrt_pre == MRT_PRE_LAST);
    end else begin
      mrt_tick = fc64_tick;
    end
    mrt_start = evt.tx_eof || cmd[CMD_START_MRT]
             || (evt.peer_on && (act_mode || mode == MODE_PAS_TGT
                                 || mode == MODE_LP_TGT));

    // Mask timer: count, stop-all, then start, so a start always wins.
    if (s.mrt_st == TMR_RUN) begin
      if (fc64_tick) next_s.mrt_pre = s.mrt_pre + 3'h1;
      if (mrt_tick) begin
        if (s.mrt_cnt <= 8'h01) begin
          next_s.mrt_st       = TMR_IDLE;
          next_s.out.rx_on    = 1'b1;
          next_s.out.watch_rx = (mode == MODE_LP_TGT);
        end else begin
          next_s.mrt_cnt = s.mrt_cnt - 8'h01;
        end
      end
    end
    if (cmd[CMD_STOP_ALL]) next_s.mrt_st = TMR_IDLE;
    if (mrt_start) begin
      next_s.mrt_st       = TMR_RUN;
      next_s.mrt_cnt      = s.mrt_val;
      next_s.mrt_pre      = 3'h0;
      next_s.out.rx_on    = 1'b0;
      next_s.out.watch_rx = 1'b0;
      next_s.mrt_sq = cmd[CMD_START_MRT] ? s.ctrl[CTRL_SQ_CMD]
                                         : s.ctrl[CTRL_SQ_AUTO];
    end
    // Squelch follows the next state, so it drops together with the timer.
    next_s.out.squelch_on = (next_s.mrt_st == TMR_RUN) && next_s.mrt_sq;

    // Response timer: tick, automatic start sources, stop requests.
    // The coarse step reuses the carrier tick through a six-bit prescaler.
    nrt_tick = fc64_tick && (!s.ctrl[CTRL_NRT_STEP]
                             || s.nrt_pre == NRT_PRE_LAST);
    // Automatic start sources depend on the operating mode.
    unique case (mode)
      MODE_READER:   nrt_auto = evt.tx_eof;
      MODE_ACT_INIT,
      MODE_ACT_TGT:  nrt_auto = s.ctrl[CTRL_NRT_NFC] ? evt.peer_on
                                                     : evt.tx_off_gpt;
      MODE_BITRATE:  nrt_auto = !s.ctrl[CTRL_NRT_NFC]
                                && evt.tx_off_gpt;
      default:       nrt_auto = 1'b0;
    endcase
    // A command start reloads a running timer, which lets software chain
    // waits longer than one register value can hold.
    nrt_start = nrt_auto || cmd[CMD_START_NRT];
    nrt_stop  = cmd[CMD_STOP_NRT]
             || (cmd[CMD_STOP_ALL] && !s.ctrl[CTRL_NRT_EMV]);

    if (s.nrt_st == TMR_RUN) begin
      if (fc64_tick) next_s.nrt_pre = s.nrt_pre + 6'h01;
      if (evt.reply_start && !s.ctrl[CTRL_NRT_EMV]) begin
        next_s.nrt_st = TMR_IDLE;
      end else if (nrt_tick) begin
        if (s.nrt_cnt <= 16'h0001) begin
          next_s.nrt_st = TMR_IDLE;
          nre_ev        = 1'b1;
          // A reply already underway survives an unconditional expiry.
          if (!s.ctrl[CTRL_NRT_EMV] || !evt.reply_busy) begin
            next_s.out.rx_on = 1'b0;
          end
        end else begin
          next_s.nrt_cnt = s.nrt_cnt - 16'h0001;
        end
      end
    end
    // A stop in the expiry cycle suppresses the interrupt.
    if (nrt_stop) begin
      next_s.nrt_st = TMR_IDLE;
      nre_ev        = 1'b0;
    end
    if (nrt_start) begin
      next_s.nrt_st  = TMR_RUN;
      next_s.nrt_cnt = s.nrt_val;
      next_s.nrt_pre = 6'h00;
    end
    // The pulse is registered so that the output comes from a flop.
    next_s.out.nre_irq = nre_ev;

    // Sticky flag: write one to clear, but a new expiry wins.
    next_s.nre_flag = (s.nre_flag
                       && !(wr_done && paddr == ADDR_FLAG && pwdata[FLAG_NRE]))
                      || nre_ev;
  end

  // ------------------------------------------------------------------
  // State register
  // ------------------------------------------------------------------
  // Everything resets to constants; rx_on starts low until a mask expiry.
  // The whole struct clears first, then named fields take their constants.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s         <= '0;
      s.ctrl    <= CTRL_RST;
      s.mrt_val <= MRT_RST;
      s.nrt_val <= NRT_RST;
      s.mrt_st  <= TMR_IDLE;
      s.nrt_st  <= TMR_IDLE;
    end else begin
      s <= next_s;
    end
  end

  // ------------------------------------------------------------------
  // Assertions: mask timer
  // ------------------------------------------------------------------
  // All checks use the bus clock and stay quiet while reset is applied.
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_mrt_rx_block: assert property (
    s.mrt_st == TMR_RUN |-> !s.out.rx_on)
    else $error("rx_on high while mask timer runs");
  a_mrt_eof_load: assert property (
    evt.tx_eof |=> s.mrt_st == TMR_RUN && s.mrt_cnt == $past(s.mrt_val))
    else $error("mask timer not loaded at end of frame");
  a_mrt_sq_auto: assert property (
    evt.tx_eof && !cmd[CMD_START_MRT]
    |=> s.out.squelch_on == $past(s.ctrl[CTRL_SQ_AUTO]))
    else $error("squelch not following auto setting");
  a_mrt_sq_cmd: assert property (
    cmd[CMD_START_MRT]
    |=> s.mrt_st == TMR_RUN && s.out.squelch_on == $past(s.ctrl[CTRL_SQ_CMD]))
    else $error("command start squelch wrong");
  a_mrt_peer_on: assert property (
    evt.peer_on && (act_mode || mode == MODE_PAS_TGT) |=> s.mrt_st == TMR_RUN)
    else $error("peer field on did not start mask timer");
  a_mrt_coarse_hold: assert property (
    s.mrt_st == TMR_RUN && s.ctrl[CTRL_MRT_STEP] && mode != MODE_LP_TGT
    && s.mrt_pre != MRT_PRE_LAST && !mrt_start && !cmd[CMD_STOP_ALL]
    |=> s.mrt_cnt == $past(s.mrt_cnt))
    else $error("mask count moved inside coarse step");
  a_lp_rc_tick: assert property (
    mode == MODE_LP_TGT && !evt.osc_ok && s.mrt_st == TMR_RUN && rc_edge
    && s.mrt_cnt > 8'h01 && !mrt_start && !cmd[CMD_STOP_ALL]
    |=> s.mrt_cnt == $past(s.mrt_cnt) - 8'h01)
    else $error("RC edge did not step mask timer");
  a_mrt_expire_once: assert property (
    s.mrt_st == TMR_RUN && mrt_tick && s.mrt_cnt <= 8'h01 && !mrt_start
    && !cmd[CMD_STOP_ALL]
    |=> s.mrt_st == TMR_IDLE && s.out.rx_on
        && s.out.watch_rx == ($past(mode) == MODE_LP_TGT))
    else $error("mask expiry wrong");
  a_stop_all_mrt: assert property (
    cmd[CMD_STOP_ALL] && !mrt_start |=> s.mrt_st == TMR_IDLE)
    else $error("stop all left mask timer running");

  // The squelch may only be on while the mask timer runs.
  a_sq_idle_off: assert property (
    s.mrt_st == TMR_IDLE |-> !s.out.squelch_on)
    else $error("squelch on with mask timer idle");
  // Fine step: every carrier tick takes one count off the mask timer.
  a_mrt_fine_step: assert property (
    s.mrt_st == TMR_RUN && !s.ctrl[CTRL_MRT_STEP] && fc64_tick && !mrt_start
    && (mode != MODE_LP_TGT || evt.osc_ok) && s.mrt_cnt > 8'h01
    |=> s.mrt_cnt == $past(s.mrt_cnt) - 8'h01)
    else $error("mask count missed a fine tick");
  // A start closes the receiver and clears the watch flag at once.
  a_mrt_start_rx: assert property (
    mrt_start |=> s.mrt_st == TMR_RUN && !s.out.rx_on && !s.out.watch_rx)
    else $error("mask start left the receiver open");

  // ------------------------------------------------------------------
  // Assertions: response timer
  // ------------------------------------------------------------------
  a_nre_flag_set: assert property (
    s.out.nre_irq |-> s.nre_flag)
    else $error("expiry without flag");
  a_nrt_expire: assert property (
    s.nrt_st == TMR_RUN && !s.ctrl[CTRL_NRT_EMV] && nrt_tick
    && s.nrt_cnt <= 16'h0001 && !evt.reply_start && !nrt_stop && !mrt_start
    |=> s.out.nre_irq && !s.out.rx_on)
    else $error("conditional expiry missed");
  a_nrt_reply_stop: assert property (
    s.nrt_st == TMR_RUN && !s.ctrl[CTRL_NRT_EMV] && evt.reply_start
    && !nrt_start |=> s.nrt_st == TMR_IDLE ##1 !s.out.nre_irq)
    else $error("reply start did not stop timer quietly");
  a_nrt_emv_keep: assert property (
    s.nrt_st == TMR_RUN && s.ctrl[CTRL_NRT_EMV] && cmd[CMD_STOP_ALL]
    && !cmd[CMD_STOP_NRT] && !nrt_tick |=> s.nrt_st == TMR_RUN)
    else $error("stop all stopped unconditional timer");
  a_nrt_reader: assert property (
    mode == MODE_READER && evt.tx_eof |=> s.nrt_st == TMR_RUN)
    else $error("response timer not started at end of transmit");
  a_nrt_restart: assert property (
    cmd[CMD_START_NRT]
    |=> s.nrt_st == TMR_RUN && s.nrt_cnt == $past(s.nrt_val))
    else $error("response timer restart failed");
  a_nrt_stop_quiet: assert property (
    nrt_stop && !nrt_start |=> s.nrt_st == TMR_IDLE && !s.out.nre_irq)
    else $error("stopped response timer interrupted");
  a_nrt_gpt_start: assert property (
    (act_mode || mode == MODE_BITRATE) && !s.ctrl[CTRL_NRT_NFC]
    && evt.tx_off_gpt |=> s.nrt_st == TMR_RUN)
    else $error("field off did not start response timer");
  a_nrt_no_auto: assert property (
    (mode == MODE_PAS_TGT || (mode == MODE_BITRATE && s.ctrl[CTRL_NRT_NFC]))
    && s.nrt_st == TMR_IDLE && !cmd[CMD_START_NRT] |=> s.nrt_st == TMR_IDLE)
    else $error("response timer started on its own");

  // nre_irq is one cycle wide unless a start reloads the timer at once.
  a_nre_pulse_once: assert property (
    s.out.nre_irq && s.nrt_st == TMR_IDLE |=> !s.out.nre_irq)
    else $error("expiry pulse longer than one cycle");
  // The sticky flag survives until software writes one to it.
  a_nre_flag_hold: assert property (
    s.nre_flag && !(wr_done && paddr == ADDR_FLAG && pwdata[FLAG_NRE])
    |=> s.nre_flag)
    else $error("expiry flag lost without a clear");
  // Conditional stop-all ends the response timer as well.
  a_stop_all_nrt: assert property (
    cmd[CMD_STOP_ALL] && !s.ctrl[CTRL_NRT_EMV] && !nrt_start
    |=> s.nrt_st == TMR_IDLE)
    else $error("stop all left response timer running");
  // Coarse step: the count only moves on every 64th carrier tick.
  a_nrt_coarse_hold: assert property (
    s.nrt_st == TMR_RUN && s.ctrl[CTRL_NRT_STEP]
    && s.nrt_pre != NRT_PRE_LAST && !nrt_start
    |=> s.nrt_cnt == $past(s.nrt_cnt))
    else $error("response count moved inside coarse step");
  // Unconditional expiry during a busy reply keeps an open receiver open.
  a_nrt_busy_keep: assert property (
    s.nrt_st == TMR_RUN && s.ctrl[CTRL_NRT_EMV] && nrt_tick && evt.reply_busy
    && s.nrt_cnt <= 16'h0001 && !nrt_stop && !mrt_start
    |=> s.out.nre_irq && (s.out.rx_on || !$past(s.out.rx_on)))
    else $error("busy reply lost the receiver at expiry");
  // A conditional expiry pulse always comes with a closed receiver.
  a_nrt_irq_rx: assert property (
    s.out.nre_irq && !$past(s.ctrl[CTRL_NRT_EMV]) |-> !s.out.rx_on)
    else $error("conditional expiry left the receiver open");

  // ------------------------------------------------------------------
  // Cover points
  // ------------------------------------------------------------------
  // Main scenarios that the bench is expected to reach.
  c_mrt_expiry: cover property (
    s.mrt_st == TMR_RUN ##1 s.mrt_st == TMR_IDLE && s.out.rx_on);
  c_nre_irq: cover property (s.out.nre_irq);
  c_reply_stop: cover property (
    s.nrt_st == TMR_RUN && evt.reply_start ##1 s.nrt_st == TMR_IDLE);
  c_lp_watch: cover property (mode == MODE_LP_TGT && s.out.watch_rx);
  c_uncond_keep: cover property (
    s.ctrl[CTRL_NRT_EMV] && s.out.nre_irq && s.out.rx_on);

endmodule : nrw_timers

// ===== test/nrw_fe_model.sv
// Front-end model: carrier tick divider and low-power RC oscillator.
`timescale 1ns/100ps
module nrw_fe_model #(
  parameter int TICK_DIV = 3,
  parameter int RC_HALF  = 7
) (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic osc_ok,
  output logic      fc64_tick,
  output logic      rc_osc_pin
);
  int tick_cnt;
  int rc_cnt;

  // The carrier tick exists only once the crystal is stable, so the RC
  // fallback path is really the only clock of the mask timer before.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_cnt  <= 0;
      fc64_tick <= 1'b0;
    end else begin
      tick_cnt  <= (tick_cnt == TICK_DIV - 1) ? 0 : tick_cnt + 1;
      fc64_tick <= osc_ok && (tick_cnt == TICK_DIV - 1);
    end
  end

  // The RC oscillator runs free; its rate is scaled to keep runs short.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rc_cnt     <= 0;
      rc_osc_pin <= 1'b0;
    end else begin
      rc_cnt     <= (rc_cnt == RC_HALF - 1) ? 0 : rc_cnt + 1;
      rc_osc_pin <= (rc_cnt == RC_HALF - 1) ? !rc_osc_pin : rc_osc_pin;
    end
  end
endmodule : nrw_fe_model

// ===== test/testbench.sv
// Self-checking testbench of the reception window timers.
`timescale 1ns/100ps
module testbench;
  import nrw_pkg::*;
  localparam logic [5:0] EV_EOF = 6'h20;
  localparam logic [5:0] EV_OFF = 6'h10;
  localparam logic [5:0] EV_PEER = 6'h08;
  localparam logic [5:0] EV_REPLY = 6'h04;
  logic        pclk    = 1'b0;
  logic        presetn = 1'b0;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [7:0]  paddr   = 8'h00;
  logic [31:0] pwdata  = 32'h0000_0000;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        fc64_tick;
  logic        rc_osc_pin;
  nrw_evt_t    evt     = nrw_evt_t'(6'h01);
  nrw_out_t    out;
  int          errors  = 0;
  int          comparisons = 0;
  logic [31:0] rdata;
  logic        rerr;
  logic        sqs;
  int          mt, nt, m, v, ms, ns, sq;

  nrw_timers u_nrw_timers (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .fc64_tick(fc64_tick), .rc_osc_pin(rc_osc_pin), .evt(evt), .out(out));
  nrw_fe_model u_nrw_fe_model (.pclk(pclk), .presetn(presetn),
    .osc_ok(evt.osc_ok), .fc64_tick(fc64_tick), .rc_osc_pin(rc_osc_pin));

  // 25 MHz bus clock.
  always #20 pclk = ~pclk;

  // ----------------------------------------------------------------
  // Tasks and expectations
  // ----------------------------------------------------------------
  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : check

  task automatic conclude;
    if (errors == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : conclude

  // One APB transfer; the request is held until pready is sampled high.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 50; i++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    rdata = prdata;
    rerr  = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (i == 50) begin
      errors++;
      conclude();
    end
  endtask : apb

  task automatic rd(input logic [7:0] a, input logic [31:0] exp,
                    input string what);
    apb(1'b0, a, 32'h0000_0000);
    check(what, rdata, exp);
  endtask : rd

  // Event strobes are one cycle wide; levels in the struct are kept.
  task automatic pulse(input logic [5:0] msk);
    @(posedge pclk);
    evt <= nrw_evt_t'(evt | msk);
    @(posedge pclk);
    evt <= nrw_evt_t'(evt & ~msk);
  endtask : pulse

  // Counts carrier ticks up to the expiry pulse; mt notes when the mask
  // released the receiver. A missing pulse leaves nt at -1.
  task automatic watch(input int lim, output int mt, output int nt,
                       output logic sq0);
    int n;
    mt = -1;
    nt = -1;
    n  = 0;
    for (int i = 0; i < lim; i++) begin
      @(posedge pclk);
      if (i == 0) sq0 = out.squelch_on;
      if (out.nre_irq === 1'b1) begin
        nt = n;
        break;
      end
      if (out.rx_on === 1'b1 && mt < 0) mt = n;
      if (fc64_tick === 1'b1) n++;
    end
  endtask : watch

  function automatic int ticks(input int val, input int crs, input int fc);
    return (val == 0 ? 1 : val) * (crs != 0 ? fc / FC_PER_BASE : 1);
  endfunction : ticks

  function automatic logic exp_nrun(input int md, input int nf, input int e);
    if (e != 0) return nf == 0 && (md == 1 || md == 2 || md == 4);
    return nf == 1 && (md == 1 || md == 2);
  endfunction : exp_nrun

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(87729));
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    rd(ADDR_CTRL, 32'h0, "ctrl reset");
    rd(ADDR_NRT, 32'h0, "nrt reset");
    rd(ADDR_FLAG, 32'h0, "flag reset");
    rd(ADDR_CMD, 32'h0, "cmd reads zero");
    rd(8'h18, 32'h0, "unmapped data");
    check("unmapped error", {31'h0, rerr}, 32'h1);
    apb(1'b1, ADDR_STAT, 32'hFFFF_FFFF);
    check("stat write error", {31'h0, rerr}, 32'h0);
    m = $urandom_range(255);
    apb(1'b1, ADDR_MRT, 32'(m));
    rd(ADDR_MRT, 32'(m), "mrt readback");
    // Automatic starts after transmit, all step combinations.
    for (int k = 0; k < 4; k++) begin
      ms = k & 1;
      ns = k >> 1;
      sq = $urandom_range(1);
      m  = $urandom_range(4);
      v  = ns ? $urandom_range(2, 1) : ticks(m, ms, MRT_COARSE_FC) + 2;
      apb(1'b1, ADDR_CTRL, 32'(sq << CTRL_SQ_AUTO | ns << 1 | ms));
      apb(1'b1, ADDR_MRT, 32'(m));
      apb(1'b1, ADDR_NRT, 32'(v));
      pulse(EV_EOF);
      watch(1000, mt, nt, sqs);
      check("squelch in mask", {31'h0, sqs}, 32'(sq));
      check("mask ticks", mt, ticks(m, ms, MRT_COARSE_FC));
      check("resp ticks", nt, ticks(v, ns, NRT_COARSE_FC));
      check("rx off at expiry", {31'h0, out.rx_on}, 32'h0);
      @(posedge pclk);
      check("single pulse", {31'h0, out.nre_irq}, 32'h0);
      rd(ADDR_FLAG, 32'h1, "flag set");
      apb(1'b1, ADDR_FLAG, 32'h1);
      rd(ADDR_FLAG, 32'h0, "flag clear");
    end
    // Reply start, stop commands and restart, conditional mode.
    apb(1'b1, ADDR_CTRL, 32'h0);
    apb(1'b1, ADDR_NRT, 32'h14);
    pulse(EV_EOF);
    pulse(EV_REPLY);
    watch(200, mt, nt, sqs);
    check("reply stops quietly", nt, -1);
    for (int k = CMD_STOP_NRT; k <= CMD_STOP_ALL; k++) begin
      apb(1'b1, ADDR_CMD, 32'h2);
      apb(1'b1, ADDR_CMD, 32'(1 << k));
      watch(200, mt, nt, sqs);
      check("stop quietly", nt, -1);
    end
    apb(1'b1, ADDR_CMD, 32'h2);
    repeat (15) @(posedge pclk);
    apb(1'b1, ADDR_CMD, 32'h2);
    watch(300, mt, nt, sqs);
    check("restart ticks", nt, 32'h14);
    // Unconditional mode ignores stop-all; a busy reply keeps the receiver.
    for (int b = 0; b < 2; b++) begin
      apb(1'b1, ADDR_CTRL, 32'h4);
      evt.reply_busy <= b[0];
      pulse(EV_EOF);
      // Let the mask expire first so the receiver is open at the timeout.
      repeat (20) @(posedge pclk);
      apb(1'b1, ADDR_CMD, 32'h8);
      watch(300, mt, nt, sqs);
      check("uncond pulse", {31'h0, nt < 0}, 32'h0);
      check("uncond rx", {31'h0, out.rx_on}, 32'(b));
      evt.reply_busy <= 1'b0;
    end
    // Command start of the mask timer takes the command squelch setting.
    apb(1'b1, ADDR_CTRL, 32'h20);
    apb(1'b1, ADDR_MRT, 32'hFF);
    apb(1'b1, ADDR_CMD, 32'h1);
    apb(1'b0, ADDR_STAT, 32'h0);
    check("cmd mask start", rdata[3:0], 32'h9);
    // Peer-to-peer start events per mode, each ended by stop-all.
    for (int md = 1; md < 6; md++)
      for (int nf = 0; nf < 2; nf++)
        for (int e = 0; e < 2; e++) begin
          apb(1'b1, ADDR_CMD, 32'h8);
          apb(0, ADDR_STAT, 32'h0);
          check("stop all", rdata[1:0], 32'h0);
          apb(1'b1, ADDR_CTRL, 32'(md << CTRL_MODE_LSB | nf << 3 | 3));
          pulse(e ? EV_OFF : EV_PEER);
          apb(1'b0, ADDR_STAT, 32'h0);
          if (e == 0 && md != 4) check("peer mask", rdata[0], 32'h1);
          check("peer resp", rdata[1], exp_nrun(md, nf, e));
        end
    apb(1'b1, ADDR_CMD, 32'h8);
    // Low-power target mode with no crystal: RC edges time the mask.
    apb(1'b1, ADDR_CTRL, 32'h501);
    apb(1'b1, ADDR_MRT, 32'h2);
    evt.osc_ok <= 1'b0;
    pulse(EV_PEER);
    for (int i = 0; i < 2000 && out.watch_rx !== 1'b1; i++) @(posedge pclk);
    check("watch after mask", {31'h0, out.watch_rx}, 32'h1);
    conclude();
  end
endmodule : testbench
